// ---- logic/gcw_defs.svh ----
// Word width, field positions, stored-bit mask and reset value of the configuration word
`ifndef GCW_DEFS_SVH
`define GCW_DEFS_SVH
`define GCW_WORD_W          16
`define GCW_BIT_DIR_IRQ_EN  10
`define GCW_BIT_SOFT_SHDN   9
`define GCW_BIT_CNT_CLR     8
`define GCW_BIT_IRQ_CLR     7
`define GCW_BIT_CNT_SEL     6
`define GCW_BIT_OFFS_MEAS   5
`define GCW_BIT_CMP_EN      4
`define GCW_BIT_DSW_HI      3
`define GCW_BIT_DSW_LO      2
`define GCW_BIT_CSW_HI      1
`define GCW_BIT_CSW_LO      0
`define GCW_STORED_MASK     16'h067F
`define GCW_RESET_VALUE     16'h0000
`endif

// ---- logic/gcw_pkg.sv ----
// Types shared by the configuration word logic
package gcw_pkg;
  typedef logic [1:0] gcw_switch_ctl_type;
endpackage

// ---- logic/gcw_pulse.sv ----
// One-cycle action pulse derived from a written bit
`include "gcw_defs.svh"
module gcw_pulse (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Request
  input  wire logic fire,
  // Pulse out
  output logic      pulse
);
  logic pulse_reg;
  logic pulse_next;

  always_comb begin
    pulse_next = fire;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;

  // The pulse follows its request by one edge and never stretches on its own
  pulse_fire_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fire |=> pulse) else $error("Action pulse missing after request");
  single_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fire |=> !pulse) else $error("Action pulse held without request");
endmodule // gcw_pulse

// ---- logic/gcw_config_word.sv ----
// Configuration word register with its field decode and write actions
// What this block does
// - Bit 10 enables the direction-change interrupt; zero suppresses it.
// - Bit 9 one enters soft shutdown; zero returns to normal operation.
// - Writing one to bit 8 clears both coulomb counters.
// - Writing one to bit 7 clears the four latched status flags.
// - Bit 6 selects charge counter when one, discharge counter when zero.
// - Bit 5 shorts current-sense input to analog ground; zero reconnects it.
// - Bit 4 enables the digital compare function and its interrupt.
// - Bits 3 and 2 set the discharge switch driver state, bit 3 upper.
// - Bits 1 and 0 set the charge switch driver state, bit 1 upper.
// - Counter-select status indicator mirrors bit 6.
`include "gcw_defs.svh"
module gcw_config_word (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // Configuration write from the serial slave
  input  wire logic                      config_write_cmd,
  input  wire logic [`GCW_WORD_W-1:0]    config_wdata,
  // Field outputs
  output logic                           dir_change_irq_en,
  output logic                           soft_shutdown_en,
  output logic                           counter_select,
  output logic                           offset_measure_en,
  output logic                           compare_en,
  output gcw_pkg::gcw_switch_ctl_type    dischg_switch_ctl,
  output gcw_pkg::gcw_switch_ctl_type    chg_switch_ctl,
  output logic                           counter_select_flag,
  // Action pulses
  output logic                           counters_clear,
  output logic                           irq_flags_clear
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Both stages clear at once on the pin; only the second stage feeds logic
  logic rst_meta_reg;
  logic rst_meta_next;
  logic rst_n_reg;
  logic rst_n_next;

  always_comb begin
    rst_meta_next = 1'b1;
    rst_n_next    = rst_meta_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= rst_meta_next;
      rst_n_reg    <= rst_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored fields
  logic [`GCW_WORD_W-1:0] cfg_reg;
  logic [`GCW_WORD_W-1:0] cfg_next;

  // Upper unused bits and the two clear bits never reach the stored word
  function automatic logic [`GCW_WORD_W-1:0] keep_stored(input logic [`GCW_WORD_W-1:0] w);
    keep_stored = w & `GCW_STORED_MASK;
  endfunction

  // Two neighbouring control bits packed as one switch driver code, upper bit first
  function automatic gcw_pkg::gcw_switch_ctl_type field_pair(input logic [`GCW_WORD_W-1:0] w,
                                                             input int                    hi,
                                                             input int                    lo);
    field_pair = {w[hi], w[lo]};
  endfunction

  always_comb begin
    cfg_next = cfg_reg;
    if (config_write_cmd) begin
      cfg_next = keep_stored(config_wdata);
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_reg <= `GCW_RESET_VALUE;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign dir_change_irq_en   = cfg_reg[`GCW_BIT_DIR_IRQ_EN];
  assign soft_shutdown_en    = cfg_reg[`GCW_BIT_SOFT_SHDN];
  assign counter_select      = cfg_reg[`GCW_BIT_CNT_SEL];
  assign counter_select_flag = cfg_reg[`GCW_BIT_CNT_SEL];
  assign offset_measure_en   = cfg_reg[`GCW_BIT_OFFS_MEAS];
  assign compare_en          = cfg_reg[`GCW_BIT_CMP_EN];
  assign dischg_switch_ctl   = field_pair(cfg_reg, `GCW_BIT_DSW_HI, `GCW_BIT_DSW_LO);
  assign chg_switch_ctl      = field_pair(cfg_reg, `GCW_BIT_CSW_HI, `GCW_BIT_CSW_LO);

  ////////////////////////////////////////////////////////////////////////////
  // Write-triggered actions
  // Each write that carries a clear bit fires one pulse; back-to-back writes fire one each
  logic cnt_clr_fire;
  logic irq_clr_fire;

  always_comb begin
    cnt_clr_fire = config_write_cmd & config_wdata[`GCW_BIT_CNT_CLR];
    irq_clr_fire = config_write_cmd & config_wdata[`GCW_BIT_IRQ_CLR];
  end

  gcw_pulse u_cnt_clr (
    .mclk  (mclk),
    .rst_n (rst_n_reg),
    .fire  (cnt_clr_fire),
    .pulse (counters_clear)
  );

  gcw_pulse u_irq_clr (
    .mclk  (mclk),
    .rst_n (rst_n_reg),
    .fire  (irq_clr_fire),
    .pulse (irq_flags_clear)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  dir_irq_en_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> dir_change_irq_en == $past(config_wdata[`GCW_BIT_DIR_IRQ_EN]))
    else $error("Direction irq enable wrong");

  dir_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> $stable(dir_change_irq_en))
    else $error("Direction irq enable changed without write");

  soft_shdn_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> soft_shutdown_en == $past(config_wdata[`GCW_BIT_SOFT_SHDN]))
    else $error("Soft shutdown wrong");

  shdn_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> $stable(soft_shutdown_en))
    else $error("Soft shutdown changed without write");

  cnt_clear_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    cnt_clr_fire |=> counters_clear)
    else $error("Counter clear missing");

  cnt_clr_idle_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !cnt_clr_fire |=> !counters_clear)
    else $error("Counter clear held without write");

  irq_clear_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    $rose(irq_flags_clear) |-> $past(irq_clr_fire))
    else $error("Spurious irq clear");

  irq_clr_set_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    irq_clr_fire |=> irq_flags_clear)
    else $error("Irq clear missing");

  irq_clr_idle_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !irq_clr_fire |=> !irq_flags_clear)
    else $error("Irq clear held without write");

  cnt_sel_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> counter_select == $past(config_wdata[`GCW_BIT_CNT_SEL]))
    else $error("Counter select wrong");

  offs_meas_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> $stable(offset_measure_en))
    else $error("Offset mode changed without write");

  offs_set_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> offset_measure_en == $past(config_wdata[`GCW_BIT_OFFS_MEAS]))
    else $error("Offset mode wrong");

  cmp_en_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> compare_en == $past(config_wdata[`GCW_BIT_CMP_EN]))
    else $error("Compare enable wrong");

  fields_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> $stable(cfg_reg))
    else $error("Stored word changed without write");

  dsw_ctl_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> dischg_switch_ctl == $past(config_wdata[3:2]))
    else $error("Discharge switch ctl wrong");

  csw_ctl_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> chg_switch_ctl == $past(config_wdata[1:0]))
    else $error("Charge switch ctl wrong");

  switch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> ($stable(dischg_switch_ctl) && $stable(chg_switch_ctl)))
    else $error("Switch ctl changed without write");

  sel_flag_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    config_write_cmd |=> counter_select_flag == $past(config_wdata[`GCW_BIT_CNT_SEL]))
    else $error("Select flag does not follow write");

  sel_flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    !config_write_cmd |=> $stable(counter_select_flag))
    else $error("Select flag changed without write");

  unused_hi_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    (config_write_cmd && config_wdata[10:0] == cfg_reg[10:0]) |=> $stable(cfg_reg))
    else $error("Unused bits had effect");

  unused_zero_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    (cfg_reg & ~`GCW_STORED_MASK) == 16'h0000)
    else $error("Unused or clear bit stored");

  pulse_once_a: assert property (@(posedge mclk) disable iff (!rst_n_reg)
    counters_clear |-> $past(cnt_clr_fire))
    else $error("Clear pulse without write");

  reset_state_a: assert property (@(posedge mclk)
    $rose(rst_n_reg) |-> (cfg_reg == `GCW_RESET_VALUE && !counters_clear && !irq_flags_clear))
    else $error("State not cleared at reset release");

  // Main scenarios: offset entry, shutdown entry, both clears, charge select, clear burst
  offs_cycle_c: cover property (@(posedge mclk) disable iff (!rst_n_reg)
    offset_measure_en && chg_switch_ctl == 2'h2 && dischg_switch_ctl == 2'h2);
  shdn_c: cover property (@(posedge mclk) disable iff (!rst_n_reg)
    $rose(soft_shutdown_en));
  clr_both_c: cover property (@(posedge mclk) disable iff (!rst_n_reg)
    counters_clear && irq_flags_clear);
  sel_chg_c: cover property (@(posedge mclk) disable iff (!rst_n_reg)
    $rose(counter_select_flag));
  clr_burst_c: cover property (@(posedge mclk) disable iff (!rst_n_reg)
    counters_clear ##1 counters_clear);
endmodule // gcw_config_word

// ---- tb/gcw_host_model.sv ----
// Host model that issues configuration word writes
module gcw_host_model (
  // Clock
  input  wire logic   mclk,
  // Write strobe and word
  output logic        config_write_cmd,
  output logic [15:0] config_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    config_write_cmd = 1'b0;
    config_wdata     = 16'hFFFF;
  end
  ////////////////////////////////////////
  // Called at a falling edge; released data is inverted so it never matches
  task automatic send(input logic [15:0] w, input bit hold, input bit raw);
    config_write_cmd = 1'b1;
    config_wdata     = raw ? w : (w & 16'hFFFB);
    @(negedge mclk);
    if (!hold) begin
      config_write_cmd = 1'b0;
      config_wdata     = ~w;
    end
  endtask
endmodule // gcw_host_model

// ---- tb/tb_gauge_config_word.sv ----
// Self-checking bench for the configuration word
module tb_gauge_config_word;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       mclk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       config_write_cmd;
  logic [15:0]                config_wdata;
  logic                       dir_change_irq_en, soft_shutdown_en, counter_select, offset_measure_en;
  logic                       compare_en, counter_select_flag, counters_clear, irq_flags_clear;
  gcw_pkg::gcw_switch_ctl_type dischg_switch_ctl, chg_switch_ctl;
  logic [11:0]                seen;
  int                         err_total = 0;
  int                         tests_run = 0;
  assign seen = {counters_clear, irq_flags_clear, dir_change_irq_en, soft_shutdown_en, counter_select,
                 offset_measure_en, compare_en, dischg_switch_ctl, chg_switch_ctl, counter_select_flag};
  always #5 mclk = ~mclk;
  gcw_host_model u_host (.mclk(mclk), .config_write_cmd(config_write_cmd), .config_wdata(config_wdata));
  gcw_config_word u_dut (.mclk(mclk), .reset_n(reset_n), .config_write_cmd(config_write_cmd),
    .config_wdata(config_wdata), .dir_change_irq_en(dir_change_irq_en), .soft_shutdown_en(soft_shutdown_en),
    .counter_select(counter_select), .offset_measure_en(offset_measure_en), .compare_en(compare_en),
    .dischg_switch_ctl(dischg_switch_ctl), .chg_switch_ctl(chg_switch_ctl),
    .counter_select_flag(counter_select_flag), .counters_clear(counters_clear),
    .irq_flags_clear(irq_flags_clear));
  ////////////////////////////////////////
  // Unused upper bits never reach an output; clear bits only show while pulsing
  function automatic logic [11:0] expect_of(input logic [15:0] w, input bit p);
    return {p & w[8], p & w[7], w[10], w[9], w[6], w[5], w[4], w[3:2], w[1:0], w[6]};
  endfunction
  task automatic cmp(input string name, input logic [11:0] e);
    tests_run++;
    if (seen !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, e, seen);
    end
  endtask
  task automatic wr(input logic [15:0] w, input bit raw, input string name);
    @(negedge mclk);
    u_host.send(w, 0, raw);
    cmp(name, expect_of(w, 1));
    @(negedge mclk);
    cmp(name, expect_of(w, 0));
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #50us;
    err_total++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    cmp("reset", 12'h000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) wr(16'h0001 << i, i == 2, "single");
    $display("test single bits done");
    @(negedge mclk);
    u_host.send(16'h0180, 1, 0);
    cmp("burst", expect_of(16'h0180, 1));
    u_host.send(16'h01C0, 1, 0);
    cmp("burst", expect_of(16'h01C0, 1));
    u_host.send(16'h0000, 0, 0);
    cmp("burst", 12'h000);
    $display("test burst done");
    wr(16'h002A, 0, "offset");
    wr(16'h064A, 0, "shutdown");
    @(negedge mclk);
    reset_n = 1'b0;
    u_host.send(16'h0740, 0, 0);
    cmp("midreset", 12'h000);
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    cmp("rerelease", 12'h000);
    wr(16'h0140, 0, "rerelease");
    $display("test offset and reset done");
    conclude();
  end
endmodule // tb_gauge_config_word
